// ### hdl/pio_pkg.sv
package pio_pkg;
  localparam int unsigned PIO_LO    = 2;
  localparam int unsigned PIO_HI    = 7;
  localparam int unsigned PIO_N     = 6;
  localparam int unsigned SYNC_LEN  = 3;
  localparam int unsigned DW        = 32;
  localparam logic [11:0] ADDR_DIR    = 12'h000;
  localparam logic [11:0] ADDR_OUT    = 12'h004;
  localparam logic [11:0] ADDR_IN     = 12'h008;
  localparam logic [11:0] ADDR_FUNC   = 12'h00c;
  localparam logic [11:0] ADDR_STAT   = 12'h010;
  localparam logic [11:0] ADDR_HCIDIR = 12'h014;
  localparam logic [11:0] ADDR_HCIOUT = 12'h018;
  localparam logic [15:0] WAKE_PIN_SELECT_KEY_IDX      = 16'h02cf;
  localparam logic [15:0] CLOCK_REQUEST_ENABLE_KEY_IDX = 16'h0246;
  localparam int unsigned F_PULLUP  = 0;
  localparam int unsigned F_CS      = 1;
  localparam int unsigned F_WAKE    = 2;
  localparam int unsigned F_ATTACH  = 3;
  localparam int unsigned F_DETACH  = 4;
  localparam int unsigned F_CLKREQ  = 5;
  localparam int unsigned F_W       = 6;
  localparam int unsigned S_DEEP    = 0;
  localparam int unsigned S_SHALLOW = 1;
  localparam int unsigned S_USB     = 2;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned CLK_REQ_MS  = 4;
  localparam int unsigned CLK_REQ_CYC = CLK_HZ / 1000 * CLK_REQ_MS;
  localparam logic [5:0]  DIR_RST   = 6'h00;
  localparam logic [5:0]  OUT_RST   = 6'h00;
  localparam logic [5:0]  PULL_RST  = 6'h3f;
  localparam logic [5:0]  FUNC_RST  = 6'h00;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {PIO_AWAKE, PIO_SHALLOW, PIO_DEEP} pio_power_e;
endpackage

// ### hdl/pio_sync.sv
module pio_sync
  import pio_pkg::*;
#(
  parameter int unsigned W = 6
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Change accepted only when stages two and three agree
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      sync_o <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      sync_o <= (s2 == s3) ? s3 : sync_o;
    end
  end
endmodule // pio_sync

// ### hdl/pio_power.sv
module pio_power
  import pio_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic sw_idle_i,
  input  wire logic deep_allow_i,
  output logic      deep_o,
  output logic      shallow_o
);
  pio_power_e state;
  pio_power_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      PIO_AWAKE:   if (sw_idle_i) next_state = deep_allow_i ? PIO_DEEP : PIO_SHALLOW;
      PIO_SHALLOW: if (!sw_idle_i) next_state = PIO_AWAKE;
                   else if (deep_allow_i) next_state = PIO_DEEP;
      PIO_DEEP:    if (!sw_idle_i) next_state = PIO_AWAKE;
    endcase
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= PIO_AWAKE;
      deep_o    <= 1'b0;
      shallow_o <= 1'b0;
    end else begin
      state     <= next_state;
      deep_o    <= (next_state == PIO_DEEP);
      shallow_o <= (next_state == PIO_SHALLOW);
    end
  end
endmodule // pio_power

// ### hdl/pio_port.sv
// Overview of operation
// (R1) Six lines, numbered two to seven, each independently an input or an output.
// (R2) Reset makes every line an input with its weak pull-down on.
// (R3) Direction and level are readable and writable by on-chip software and by host commands.
// (R4) Line two is a plain line on UART parts and may drive the D+ pull-up on USB parts.
// (R5) Line two may also be an external RAM chip select output.
// (R6) On USB parts the wake pin select key picks line three as plain line or USB wake.
// (R7) On USB parts lines four and five may be attach sense and detach; otherwise plain.
// (R8) When enabled, line six is clock request: low in deep sleep, high when clock needed.
// (R9) The external source must deliver the clock within 4 ms of clock request rising.
// (R10) Line seven has no alternate function.
// (R11) Idle software drops the device into shallow or deep sleep, reported by clock request; the code lowers clock request in deep sleep only.
// (R12) Inputs pass a synchroniser before reading; enables change the cycle after a write.
module pio_port
  import pio_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             usb_variant_i,
  input  wire logic             sw_idle_i,
  input  wire logic             deep_allow_i,
  input  wire logic             usb_pullup_i,
  input  wire logic             ram_cs_i,
  input  wire logic             usb_wake_i,
  input  wire logic             usb_detach_i,
  input  wire logic             clk_ready_i,
  input  wire logic [PIO_N-1:0] general_io_line_i,
  output logic      [PIO_N-1:0] general_io_line_o,
  output logic      [PIO_N-1:0] general_io_line_oe_n_o,
  output logic      [PIO_N-1:0] general_io_line_pulldown_o,
  output logic                  usb_attach_o,
  output logic                  clk_late_o,
  input  wire logic             hsel_i,
  input  wire logic [11:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [DW-1:0]    hwdata_i,
  input  wire logic             hready_i,
  output logic      [DW-1:0]    hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o
);
  logic [PIO_N-1:0] dir;
  logic [PIO_N-1:0] out_lvl;
  logic [F_W-1:0]   func;
  logic             wr_pend;
  logic [11:0]      wr_addr;
  logic [PIO_N-1:0] in_sync;
  logic             deep;
  logic             shallow;
  logic [$clog2(CLK_REQ_CYC+1)-1:0] req_cnt;
  logic             clkreq_q;

  pio_sync #(.W(PIO_N)) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .async_i  (general_io_line_i),
    .sync_o   (in_sync)
  ); // see (R12)

  pio_power u_power (
    .mclk_i       (mclk_i),
    .resetn_i     (resetn_i),
    .sw_idle_i    (sw_idle_i),
    .deep_allow_i (deep_allow_i),
    .deep_o       (deep),
    .shallow_o    (shallow)
  ); // see (R11)

  // Bus decode
  wire        take    = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  wire        take_wr = take && hwrite_i;
  wire        take_rd = take && !hwrite_i;
  wire [11:0] rd_addr = haddr_i & 12'hffc;
  wire        wr_dir  = wr_pend && (wr_addr == ADDR_DIR || wr_addr == ADDR_HCIDIR);
  wire        wr_out  = wr_pend && (wr_addr == ADDR_OUT || wr_addr == ADDR_HCIOUT);
  wire        wr_func = wr_pend && wr_addr == ADDR_FUNC;

  // Alternate functions only on the variants that allow them
  wire        usb     = usb_variant_i;
  wire        alt2    = (usb && func[F_PULLUP]) || func[F_CS]; // see (R4) (R5)
  wire        alt3    = usb && func[F_WAKE];   // see (R6)
  wire        alt4    = usb && func[F_ATTACH]; // see (R7)
  wire        alt5    = usb && func[F_DETACH]; // see (R7)
  wire        alt6    = func[F_CLKREQ];        // see (R8)
  wire        clkreq  = !deep;                 // see (R8) (R11)
  wire        line2_v = func[F_CS] ? ram_cs_i : usb_pullup_i;

  // Line seven (index five) never takes an alternate function
  wire [PIO_N-1:0] alt_en = {1'b0, alt6, alt5, alt4, alt3, alt2}; // see (R10)
  wire [PIO_N-1:0] alt_oe = {1'b0, alt6, alt5, 1'b0, alt3, alt2};
  wire [PIO_N-1:0] alt_v  = {1'b0, clkreq, usb_detach_i, 1'b0, usb_wake_i, line2_v};
  wire [PIO_N-1:0] drv    = (dir & ~alt_en) | alt_oe; // see (R1)
  wire [PIO_N-1:0] lvl    = (out_lvl & ~alt_en) | (alt_v & alt_en);

  wire [DW-1:0] rd_stat = {{(DW-3){1'b0}}, usb, shallow, deep};
  wire [DW-1:0] rd_mux  =
      (rd_addr == ADDR_DIR || rd_addr == ADDR_HCIDIR) ? {{(DW-PIO_N){1'b0}}, dir} :
      (rd_addr == ADDR_OUT || rd_addr == ADDR_HCIOUT) ? {{(DW-PIO_N){1'b0}}, out_lvl} :
      (rd_addr == ADDR_IN)   ? {{(DW-PIO_N){1'b0}}, in_sync} :
      (rd_addr == ADDR_FUNC) ? {{(DW-F_W){1'b0}}, func} :
      (rd_addr == ADDR_STAT) ? rd_stat : '0; // see (R3)

  // Address phase latched, write lands in the data phase
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= take_wr;
      wr_addr <= haddr_i & 12'hffc;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir     <= DIR_RST;  // see (R2)
      out_lvl <= OUT_RST;
      func    <= FUNC_RST;
    end else begin
      if (wr_dir)  dir     <= hwdata_i[PIO_N-1:0]; // see (R3)
      if (wr_out)  out_lvl <= hwdata_i[PIO_N-1:0]; // see (R3)
      if (wr_func) func    <= hwdata_i[F_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take_rd) hrdata_o <= rd_mux;
    end
  end

  // Pins registered, so enables follow one cycle after the write lands
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_io_line_o          <= OUT_RST;
      general_io_line_oe_n_o     <= ~DIR_RST;  // see (R2)
      general_io_line_pulldown_o <= PULL_RST;  // see (R2)
      usb_attach_o               <= 1'b0;
    end else begin
      general_io_line_o          <= lvl;
      general_io_line_oe_n_o     <= ~drv;      // see (R12)
      general_io_line_pulldown_o <= ~drv;
      usb_attach_o               <= alt4 && in_sync[2]; // see (R7)
    end
  end

  // Watches the far side; flags a clock that misses its window
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clkreq_q   <= 1'b0;
      req_cnt    <= '0;
      clk_late_o <= 1'b0;
    end else begin
      clkreq_q <= alt6 && clkreq;
      if (!(alt6 && clkreq) || clk_ready_i) begin
        req_cnt <= '0;
      end else if (req_cnt != CLK_REQ_CYC[$bits(req_cnt)-1:0]) begin
        req_cnt <= req_cnt + 1'b1;
      end
      clk_late_o <= alt6 && clkreq && !clk_ready_i &&
                    req_cnt == CLK_REQ_CYC[$bits(req_cnt)-1:0]; // see (R9)
    end
  end
endmodule // pio_port

// ### tb/pio_board.sv
module pio_board (
  input  wire logic        mclk_i,
  input  wire logic [5:0]  o_i,
  input  wire logic [5:0]  oe_n_i,
  input  wire logic [5:0]  pd_i,
  input  wire logic [5:0]  ext_i,
  input  wire logic [5:0]  ext_en_i,
  input  wire logic [15:0] dly_i,
  output logic      [5:0]  pin_o,
  output logic             clk_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0]  last = 6'h00;
  logic [15:0] cnt  = 16'h0000;
  // Floating line without pull shows the inverse of its last level
  assign pin_o = ~oe_n_i & o_i | oe_n_i & ext_en_i & ext_i | oe_n_i & ~ext_en_i & ~pd_i & ~last;
  // Clock source starts dly_i cycles after the request line rises
  assign clk_ready_o = pin_o[4] && cnt >= dly_i;
  always_ff @(posedge mclk_i) begin
    last <= pin_o;
    cnt  <= pin_o[4] ? cnt + 16'(cnt != 16'hffff) : 16'h0000;
  end
endmodule // pio_board

// ### tb/pio_port_checker.sv
module pio_port_checker
  import pio_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        usb_variant_i,
  input wire logic        clk_ready_i,
  input wire logic [5:0]  general_io_line_o,
  input wire logic [5:0]  general_io_line_oe_n_o,
  input wire logic [5:0]  general_io_line_pulldown_o,
  input wire logic        usb_attach_o,
  input wire logic        clk_late_o,
  input wire logic        hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus stall or error");
  a_reset_input: assert property ($rose(resetn_i) |-> &general_io_line_oe_n_o && &general_io_line_pulldown_o) else $error("not input after reset");
  a_pull_idle: assert property (general_io_line_pulldown_o == general_io_line_oe_n_o) else $error("pull wrong");
  a_dir_line7: assert property (take && hwrite_i && haddr_i == ADDR_DIR |=> ##2 general_io_line_oe_n_o[5] == !$past(hwdata_i[5], 2)) else $error("line7 dir");
  a_out_line7: assert property (take && hwrite_i && haddr_i == ADDR_OUT |=> ##2 (general_io_line_oe_n_o[5] || general_io_line_o[5] == $past(hwdata_i[5], 2))) else $error("line7 level");
  a_unmapped_zero: assert property (take && !hwrite_i && haddr_i > ADDR_HCIOUT |=> hrdata_o == 32'h0) else $error("unmapped read");
  a_late_cause: assert property ($rose(clk_late_o) |-> !$past(clk_ready_i, 1)) else $error("late with clock");
  a_attach_uart: assert property ((!usb_variant_i) [*3] |-> !usb_attach_o) else $error("attach on uart");
  c_write: cover property (take && hwrite_i);
  c_late: cover property ($rose(clk_late_o));
  c_attach: cover property ($rose(usb_attach_o));
endmodule // pio_port_checker
bind pio_port pio_port_checker chk (.*);

// ### tb/testbench.sv
module testbench
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] wa, ra; logic [31:0] wd, ex;} pio_row_s;
  logic mclk_i = 1'b0, resetn_i = 1'b0, usb_variant_i = 1'b0, sw_idle_i = 1'b0;
  logic deep_allow_i = 1'b0, usb_pullup_i = 1'b0, ram_cs_i = 1'b0, usb_wake_i = 1'b0;
  logic usb_detach_i = 1'b0, hsel_i = 1'b1, hwrite_i = 1'b0;
  logic usb_attach_o, clk_late_o, clk_ready_i, hreadyout_o, hresp_o;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0]  htrans_i = 2'b00;
  logic [2:0]  hsize_i = 3'b010;
  logic [31:0] hwdata_i = 32'h0, hrdata_o, rd;
  logic [5:0]  general_io_line_i, general_io_line_o, general_io_line_oe_n_o;
  logic [5:0]  general_io_line_pulldown_o, ext = 6'h00, ext_en = 6'h00;
  logic [15:0] dly = 16'h000a;
  wire         hready_i = hreadyout_o;
  int          error_cnt = 0, cmp_count = 0;
  pio_row_s rows[6] = '{'{ADDR_DIR, ADDR_DIR, 32'hffffffff, 32'h3f},
    '{ADDR_OUT, ADDR_OUT, 32'h15, 32'h15}, '{ADDR_HCIDIR, ADDR_DIR, 32'h0, 32'h0},
    '{ADDR_HCIOUT, ADDR_OUT, 32'h2a, 32'h2a}, '{ADDR_FUNC, ADDR_FUNC, 32'h3f, 32'h3f},
    '{ADDR_FUNC, 12'h020, 32'h0, 32'h0}};
  pio_board board (.mclk_i, .o_i(general_io_line_o), .oe_n_i(general_io_line_oe_n_o),
    .pd_i(general_io_line_pulldown_o), .ext_i(ext), .ext_en_i(ext_en), .dly_i(dly),
    .pin_o(general_io_line_i), .clk_ready_o(clk_ready_i));
  pio_port dut (.*);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans_i <= HTRANS_NONSEQ;
    haddr_i  <= a;
    hwrite_i <= w;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #50 mclk_i = ~mclk_i;
  // Sized for the 40010-cycle late-clock wait plus margin
  initial begin
    wt(45000);
    error_cnt++;
    results();
  end
  initial begin
    wt(4);
    resetn_i <= 1'b1;
    wt(1);
    cmp("oe_n", 32'h3f, 32'(general_io_line_oe_n_o));
    cmp("pull", 32'h3f, 32'(general_io_line_pulldown_o));
    xfer(1'b0, ADDR_DIR, 32'h0);
    cmp("dir", 32'h0, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, rows[i].wd);
      xfer(1'b0, rows[i].ra, 32'h0);
      cmp("reg", rows[i].ex, rd);
    end
    $display("test registers done");
    xfer(1'b1, ADDR_DIR, 32'h3f);
    xfer(1'b1, ADDR_OUT, 32'h2d);
    wt(3);
    cmp("pins", 32'h2d, 32'(general_io_line_i));
    xfer(1'b1, ADDR_DIR, 32'h0);
    ext_en <= 6'h3f;
    ext <= 6'h2b;
    wt(6);
    xfer(1'b0, ADDR_IN, 32'h0);
    cmp("in", 32'h2b, rd);
    ext_en <= 6'h04;
    ext <= 6'h04;
    {usb_variant_i, ram_cs_i, usb_wake_i, usb_detach_i} <= 4'hf;
    xfer(1'b1, ADDR_FUNC, 32'h1e);
    wt(6);
    cmp("alt", 32'hf, 32'(general_io_line_i[3:0]));
    cmp("attach", 32'h1, 32'(usb_attach_o));
    usb_variant_i <= 1'b0;
    wt(6);
    cmp("uart", 32'h5, 32'(general_io_line_i[3:0]));
    cmp("attach_uart", 32'h0, 32'(usb_attach_o));
    {usb_variant_i, usb_pullup_i, ram_cs_i} <= 3'b110;
    xfer(1'b1, ADDR_FUNC, 32'h01);
    wt(4);
    cmp("pullup", 32'h1, 32'(general_io_line_i[0]));
    usb_variant_i <= 1'b0;
    wt(4);
    cmp("pullup_uart", 32'h0, 32'(general_io_line_i[0]));
    usb_variant_i <= 1'b1;
    $display("test lines done");
    xfer(1'b1, ADDR_FUNC, 32'h20);
    sw_idle_i <= 1'b1;
    wt(6);
    xfer(1'b0, ADDR_STAT, 32'h0);
    cmp("stat", 32'h6, rd);
    cmp("creq", 32'h1, 32'(general_io_line_i[4]));
    sw_idle_i <= 1'b0;
    wt(3);
    {sw_idle_i, deep_allow_i} <= 2'b11;
    wt(6);
    xfer(1'b0, ADDR_STAT, 32'h0);
    cmp("stat", 32'h5, rd);
    cmp("creq", 32'h0, 32'(general_io_line_i[4]));
    sw_idle_i <= 1'b0;
    wt(20);
    cmp("creq", 32'h1, 32'(general_io_line_i[4]));
    cmp("late", 32'h0, 32'(clk_late_o));
    sw_idle_i <= 1'b1;
    dly <= 16'hffff;
    wt(6);
    sw_idle_i <= 1'b0;
    wt(40010);
    cmp("late", 32'h1, 32'(clk_late_o));
    $display("test clock request done");
    resetn_i <= 1'b0;
    wt(2);
    cmp("oe_n_rst", 32'h3f, 32'(general_io_line_oe_n_o));
    cmp("pull_rst", 32'h3f, 32'(general_io_line_pulldown_o));
    cmp("late_rst", 32'h0, 32'(clk_late_o));
    resetn_i <= 1'b1;
    wt(1);
    xfer(1'b0, ADDR_FUNC, 32'h0);
    cmp("func_rst", 32'h0, rd);
    $display("test second reset done");
    results();
  end
endmodule // testbench
